// ==== hw/ext_irq4_5_edge_filter.sv ====
`timescale 1ns/1ns
`include "ext_irq_params.svh"

module ext_irq4_5_edge_filter
  import ext_irq_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        extIrq4Pin,
  input  wire logic        extIrq5Pin,
  input  wire logic        lowFreqClock,
  input  opmode_type       opMode,
  output logic             irq4Req,
  output logic             irq5Req,
  output logic             irqOut
);

  logic                fastMode;
  logic                slowMode;
  logic                active;
  logic                tick4;
  logic                tick5;
  logic                filt4;
  logic                filt5;
  logic                evt4;
  logic                evt5;
  logic                addrValid;
  logic [7:0]          addrOfs;
  logic [31:0]         readMux;
  logic [`EVT_W-1:0]   events;

  logic [1:0]          trig_ff;
  logic [1:0]          noise_ff;
  logic                snap_ff;
  logic [`EVT_W-1:0]   clkEn_ff;
  logic [`EVT_W-1:0]   status_ff;
  logic [`EVT_W-1:0]   mask_ff;
  logic                prev4_ff;
  logic                prev5_ff;
  logic                req4_ff;
  logic                req5_ff;
  logic                irq_ff;
  logic                dWrite_ff;
  logic [7:0]          dAddr_ff;
  logic [31:0]         rdata_ff;

  logic [1:0]          nxt_trig;
  logic [1:0]          nxt_noise;
  logic                nxt_snap;
  logic [`EVT_W-1:0]   nxt_clkEn;
  logic [`EVT_W-1:0]   nxt_status;
  logic [`EVT_W-1:0]   nxt_mask;
  logic                nxt_dWrite;
  logic [7:0]          nxt_dAddr;
  logic [31:0]         nxt_rdata;

  assign fastMode = (opMode == MODE_FAST_RUN) || (opMode == MODE_FAST_IDLE);
  assign slowMode = (opMode == MODE_SLOW_RUN) || (opMode == MODE_SLOW_SLEEP);
  assign active   = fastMode || slowMode;

  sample_tick_gen #(
    .DIV_W        (4)
  ) u_ticks (
    .clock        (clock),
    .rst_b        (rst_b),
    .lowFreqClock (lowFreqClock),
    .intervalSel  (noise_ff),
    .fastMode     (fastMode),
    .slowMode     (slowMode),
    .tick4        (tick4),
    .tick5        (tick5)
  );

  irq_noise_filter u_filter4 (
    .clock        (clock),
    .rst_b        (rst_b),
    .pinIn        (extIrq4Pin),
    .sampleTick   (tick4 && clkEn_ff[`EVT_IRQ4_BIT]),
    .threeSamples (fastMode),
    .level        (filt4)
  );

  irq_noise_filter u_filter5 (
    .clock        (clock),
    .rst_b        (rst_b),
    .pinIn        (extIrq5Pin),
    .sampleTick   (tick5 && clkEn_ff[`EVT_IRQ5_BIT]),
    .threeSamples (1'b0),
    .level        (filt5)
  );

  // request generation
  always_comb begin
    evt4 = 1'b0;
    if (clkEn_ff[`EVT_IRQ4_BIT] && active) begin
      unique case (trig_ff)
        `TRIG_RISE: evt4 = filt4 && !prev4_ff;
        `TRIG_FALL: evt4 = !filt4 && prev4_ff;
        `TRIG_BOTH: evt4 = filt4 != prev4_ff;
        `TRIG_HIGH: evt4 = filt4;
      endcase
    end
    evt5 = clkEn_ff[`EVT_IRQ5_BIT] && active && prev5_ff && !filt5;
    events = '0;
    events[`EVT_IRQ4_BIT] = evt4;
    events[`EVT_IRQ5_BIT] = evt5;
  end

  // ahb-lite slave: zero wait states, reads registered in the address phase
  assign addrValid = hsel && hready && htrans[`HTRANS_ACTIVE];
  assign addrOfs   = haddr[7:0];

  always_comb begin
    readMux = 32'h0000_0000;
    unique case (addrOfs)
      `OFS_CONTROL: begin
        readMux[`CTL_TRIG_MSB:`CTL_TRIG_LSB]   = trig_ff;
        readMux[`CTL_NOISE_MSB:`CTL_NOISE_LSB] = noise_ff;
        readMux[`CTL_SNAP_BIT]                 = snap_ff;
      end
      `OFS_CLK_ENABLE: readMux[`EVT_W-1:0] = clkEn_ff;
      `OFS_STATUS:     readMux[`EVT_W-1:0] = status_ff;
      `OFS_MASK:       readMux[`EVT_W-1:0] = mask_ff;
      default:         readMux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    nxt_dWrite = addrValid && hwrite;
    nxt_dAddr  = addrValid ? addrOfs : dAddr_ff;
    nxt_rdata  = (addrValid && !hwrite) ? readMux : rdata_ff;
    nxt_trig   = trig_ff;
    nxt_noise  = noise_ff;
    nxt_clkEn  = clkEn_ff;
    nxt_mask   = mask_ff;
    nxt_status = status_ff;
    if (dWrite_ff) begin
      unique case (dAddr_ff)
        `OFS_CONTROL: begin
          nxt_trig  = hwdata[`CTL_TRIG_MSB:`CTL_TRIG_LSB];
          nxt_noise = hwdata[`CTL_NOISE_MSB:`CTL_NOISE_LSB];
        end
        `OFS_CLK_ENABLE: nxt_clkEn  = hwdata[`EVT_W-1:0];
        `OFS_STATUS:     nxt_status = status_ff & ~hwdata[`EVT_W-1:0];
        `OFS_MASK:       nxt_mask   = hwdata[`EVT_W-1:0];
        default:         nxt_status = status_ff;
      endcase
    end
    // a new event wins over a same-cycle write-one clear
    nxt_status = nxt_status | events;
    nxt_snap = evt4 ? filt4 : snap_ff;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      trig_ff   <= `RST_TRIG;
      noise_ff  <= `RST_NOISE;
      snap_ff   <= 1'b0;
      clkEn_ff  <= `RST_CLK_ENABLE;
      status_ff <= `RST_STATUS;
      mask_ff   <= `RST_MASK;
      prev4_ff  <= 1'b0;
      prev5_ff  <= 1'b0;
      req4_ff   <= 1'b0;
      req5_ff   <= 1'b0;
      irq_ff    <= 1'b0;
      dWrite_ff <= 1'b0;
      dAddr_ff  <= 8'h00;
      rdata_ff  <= 32'h0000_0000;
    end else begin
      trig_ff   <= nxt_trig;
      noise_ff  <= nxt_noise;
      snap_ff   <= nxt_snap;
      clkEn_ff  <= nxt_clkEn;
      status_ff <= nxt_status;
      mask_ff   <= nxt_mask;
      prev4_ff  <= filt4;
      prev5_ff  <= filt5;
      req4_ff   <= evt4;
      req5_ff   <= evt5;
      irq_ff    <= |(nxt_status & nxt_mask);
      dWrite_ff <= nxt_dWrite;
      dAddr_ff  <= nxt_dAddr;
      rdata_ff  <= nxt_rdata;
    end
  end

  assign hrdata    = rdata_ff;
  assign hreadyout = 1'b1;
  assign hresp     = `HRESP_OKAY;
  assign irq4Req   = req4_ff;
  assign irq5Req   = req5_ff;
  assign irqOut    = irq_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_falling_only: assert property (irq5Req |-> $past(filt5, 2) && !$past(filt5, 1))
    else $error("pin 5 request without a falling edge");
  a_snap_capture: assert property (irq4Req |-> snap_ff == $past(filt4))
    else $error("snapshot does not hold the requesting level");
  a_both_edges: assert property (irq4Req && $past(trig_ff) == `TRIG_BOTH
    |-> snap_ff != $past(prev4_ff))
    else $error("both-edge snapshot does not show edge direction");
  a_rise_select: assert property (irq4Req && $past(trig_ff) == `TRIG_RISE
    |-> snap_ff && !$past(prev4_ff))
    else $error("rising mode request without rising edge");
  a_fall_select: assert property (irq4Req && $past(trig_ff) == `TRIG_FALL |-> !snap_ff)
    else $error("falling mode request on high level");
  a_fall_prev: assert property (irq4Req && $past(trig_ff) == `TRIG_FALL
    |-> $past(prev4_ff))
    else $error("falling mode request without a prior high level");
  a_level_hold: assert property (trig_ff == `TRIG_HIGH && filt4 && clkEn_ff[`EVT_IRQ4_BIT]
    && active |=> irq4Req)
    else $error("high level mode dropped its request");
  a_level_snap: assert property (irq4Req && $past(trig_ff) == `TRIG_HIGH |-> snap_ff)
    else $error("high level request with a low snapshot");
  a_snap_hold: assert property (!irq4Req |-> $stable(snap_ff))
    else $error("snapshot changed without a request");
  a_halt_snap: assert property (!active |=> $stable(snap_ff))
    else $error("snapshot changed in a halted mode");
  a_deep_quiet: assert property (!active
    |=> !irq4Req && !irq5Req && $stable(filt4) && $stable(filt5))
    else $error("activity in a halted mode");
  a_clock_gate: assert property (!clkEn_ff[`EVT_IRQ4_BIT]
    |=> !irq4Req ##1 !irq4Req || clkEn_ff[`EVT_IRQ4_BIT])
    else $error("pin 4 request while its clock is gated");
  a_gate_pin5: assert property (!clkEn_ff[`EVT_IRQ5_BIT] |=> !irq5Req)
    else $error("pin 5 request while its clock is gated");
  a_gate_filter4: assert property (!clkEn_ff[`EVT_IRQ4_BIT] |=> $stable(filt4))
    else $error("pin 4 filter moved while its clock is gated");
  a_gate_filter5: assert property (!clkEn_ff[`EVT_IRQ5_BIT] |=> $stable(filt5))
    else $error("pin 5 filter moved while its clock is gated");
  a_pulse5_once: assert property (irq5Req |=> !irq5Req)
    else $error("pin 5 request longer than one cycle");
  a_event_latch4: assert property (irq4Req |-> status_ff[`EVT_IRQ4_BIT])
    else $error("pin 4 request not latched in status");
  a_event_latch5: assert property (irq5Req |-> status_ff[`EVT_IRQ5_BIT])
    else $error("pin 5 request not latched in status");
  a_status_sticky4: assert property ($fell(status_ff[`EVT_IRQ4_BIT]) |-> $past(dWrite_ff)
    && $past(dAddr_ff) == `OFS_STATUS && $past(hwdata[`EVT_IRQ4_BIT]))
    else $error("pin 4 status cleared without a write of one");
  a_status_sticky5: assert property ($fell(status_ff[`EVT_IRQ5_BIT]) |-> $past(dWrite_ff)
    && $past(dAddr_ff) == `OFS_STATUS && $past(hwdata[`EVT_IRQ5_BIT]))
    else $error("pin 5 status cleared without a write of one");
  a_irq_level: assert property (status_ff[`EVT_IRQ5_BIT] && mask_ff[`EVT_IRQ5_BIT] |-> irqOut)
    else $error("interrupt low with unmasked status");
  a_irq_quiet: assert property ((status_ff & mask_ff) == '0 |-> !irqOut)
    else $error("interrupt high with no unmasked status");
  a_upper_zero: assert property (hrdata[31:`CTL_SNAP_BIT+1] == '0)
    else $error("read data upper bits not zero");
  a_trig_write: assert property ($past(dWrite_ff) && $past(dAddr_ff) == `OFS_CONTROL
    |-> trig_ff == $past(hwdata[`CTL_TRIG_MSB:`CTL_TRIG_LSB]))
    else $error("trigger select write lost");
  a_mask_write: assert property ($past(dWrite_ff) && $past(dAddr_ff) == `OFS_MASK
    |-> mask_ff == $past(hwdata[`EVT_W-1:0]))
    else $error("mask write lost");
  a_enable_write: assert property ($past(dWrite_ff) && $past(dAddr_ff) == `OFS_CLK_ENABLE
    |-> clkEn_ff == $past(hwdata[`EVT_W-1:0]))
    else $error("clock enable write lost");

  c_both_edges: cover property (trig_ff == `TRIG_BOTH && irq4Req ##[1:200] irq4Req);
  c_slow_req5: cover property (slowMode && irq5Req);
  c_clear_race: cover property (dWrite_ff && dAddr_ff == `OFS_STATUS && |events);
  c_level_mode: cover property (trig_ff == `TRIG_HIGH && irq4Req ##1 irq4Req);
  c_fast_req5: cover property (fastMode && irq5Req);

endmodule // ext_irq4_5_edge_filter

// ==== hw/ext_irq_params.svh ====
`ifndef EXT_IRQ_PARAMS_SVH
`define EXT_IRQ_PARAMS_SVH

// register byte offsets
`define OFS_CONTROL      8'h00
`define OFS_CLK_ENABLE   8'h04
`define OFS_STATUS       8'h08
`define OFS_MASK         8'h0c

// control register fields
`define CTL_TRIG_LSB     0
`define CTL_TRIG_MSB     1
`define CTL_NOISE_LSB    2
`define CTL_NOISE_MSB    3
`define CTL_SNAP_BIT     4

// event bits in enable, status and mask
`define EVT_IRQ4_BIT     0
`define EVT_IRQ5_BIT     1
`define EVT_W            2

// reset values
`define RST_TRIG         2'h0
`define RST_NOISE        2'h0
`define RST_CLK_ENABLE   2'h0
`define RST_STATUS       2'h0
`define RST_MASK         2'h0

// trigger select codes
`define TRIG_RISE        2'h0
`define TRIG_FALL        2'h1
`define TRIG_BOTH        2'h2
`define TRIG_HIGH        2'h3

// sampling interval codes and divider masks
`define NOISE_DIV1       2'h0
`define NOISE_DIV4       2'h1
`define NOISE_DIV8       2'h2
`define NOISE_DIV16      2'h3
`define MASK_DIV1        4'h0
`define MASK_DIV4        4'h3
`define MASK_DIV8        4'h7
`define MASK_DIV16       4'hf

// low frequency clock divided by four
`define LF_DIV_LAST      2'h3

// ahb-lite
`define HTRANS_ACTIVE    1
`define HRESP_OKAY       1'h0

`endif

// ==== hw/ext_irq_pkg.sv ====
package ext_irq_pkg;

  typedef enum logic [2:0] {
    MODE_FAST_RUN,
    MODE_FAST_IDLE,
    MODE_SLOW_RUN,
    MODE_SLOW_SLEEP,
    MODE_DEEP_IDLE,
    MODE_DEEP_SLEEP,
    MODE_STOP
  } opmode_type;

endpackage

// ==== hw/irq_noise_filter.sv ====
`timescale 1ns/1ns
`include "ext_irq_params.svh"

module irq_noise_filter
  import ext_irq_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic pinIn,
  input  wire logic sampleTick,
  input  wire logic threeSamples,
  output logic      level
);

  logic       pinSync_ff;
  logic [1:0] hist_ff;
  logic       level_ff;
  logic       nxt_pinSync;
  logic [1:0] nxt_hist;
  logic       nxt_level;

  always_comb begin
    nxt_pinSync = pinIn;
    nxt_hist    = hist_ff;
    nxt_level   = level_ff;
    if (sampleTick) begin
      nxt_hist = {hist_ff[0], pinSync_ff};
      // a short burst between samples is lost, never partly accepted
      // equal samples
      if (pinSync_ff == hist_ff[0] && (!threeSamples || pinSync_ff == hist_ff[1])) begin
        nxt_level = pinSync_ff;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pinSync_ff <= 1'b0;
      hist_ff    <= 2'h0;
      level_ff   <= 1'b0;
    end else begin
      pinSync_ff <= nxt_pinSync;
      hist_ff    <= nxt_hist;
      level_ff   <= nxt_level;
    end
  end

  assign level = level_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_filter_accept: assert property ($changed(level_ff) |-> $past(sampleTick)
    && $past(hist_ff[0]) == level_ff
    && (!$past(threeSamples) || $past(hist_ff[1]) == level_ff))
    else $error("filtered level changed without enough equal samples");

endmodule // irq_noise_filter

// ==== hw/sample_tick_gen.sv ====
`timescale 1ns/1ns
`include "ext_irq_params.svh"

module sample_tick_gen
  import ext_irq_pkg::*;
#(
  parameter int DIV_W = 4
)
(
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       lowFreqClock,
  input  wire logic [1:0] intervalSel,
  input  wire logic       fastMode,
  input  wire logic       slowMode,
  output logic            tick4,
  output logic            tick5
);

  logic [DIV_W-1:0] divCount_ff;
  logic [1:0]       lfCount_ff;
  logic             lfPrev_ff;
  logic [DIV_W-1:0] nxt_divCount;
  logic [1:0]       nxt_lfCount;
  logic [DIV_W-1:0] divMask;
  logic             lfRise;
  logic             fastTick;
  logic             slowTick;

  always_comb begin
    unique case (intervalSel)
      `NOISE_DIV1: divMask = `MASK_DIV1;
      `NOISE_DIV4: divMask = `MASK_DIV4;
      `NOISE_DIV8: divMask = `MASK_DIV8;
      `NOISE_DIV16: divMask = `MASK_DIV16;
    endcase
    lfRise   = lowFreqClock && !lfPrev_ff;
    fastTick = fastMode && ((divCount_ff & divMask) == divMask);
    slowTick = slowMode && lfRise && (lfCount_ff == `LF_DIV_LAST);
    nxt_divCount = fastMode ? divCount_ff + 1'b1 : divCount_ff;
    nxt_lfCount  = (slowMode && lfRise) ? lfCount_ff + 1'b1 : lfCount_ff;
    tick4 = fastTick || slowTick;
    tick5 = fastMode || slowTick;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      divCount_ff <= '0;
      lfCount_ff  <= 2'h0;
      lfPrev_ff   <= 1'b0;
    end else begin
      divCount_ff <= nxt_divCount;
      lfCount_ff  <= nxt_lfCount;
      lfPrev_ff   <= lowFreqClock;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_fast_interval: assert property (fastTick && intervalSel == `NOISE_DIV16
    |-> divCount_ff == `MASK_DIV16)
    else $error("divide by sixteen tick off its count");
  a_slow_divide: assert property (slowTick
    |-> lfCount_ff == `LF_DIV_LAST && $rose(lowFreqClock))
    else $error("slow tick not on fourth low clock edge");

endmodule // sample_tick_gen

// ==== verification/irq_pin_source.sv ====
`timescale 1ns/1ns

module irq_pin_source #(
  parameter int LF_HALF = 4
)
(
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic lvl4,
  input  wire logic lvl5,
  input  wire logic outMode,
  output logic      pin4,
  output logic      pin5,
  output logic      lfClock
);
  int lfCnt;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pin4 <= 1'b0;
      pin5 <= 1'b1;
    end else begin
      pin4 <= lvl4 & ~outMode;
      pin5 <= lvl5 & ~outMode;
    end
  end

  // low clock runs free, so slow sampling never waits on the source
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lfCnt   <= 0;
      lfClock <= 1'b0;
    end else if (lfCnt == LF_HALF - 1) begin
      lfCnt   <= 0;
      lfClock <= ~lfClock;
    end else begin
      lfCnt <= lfCnt + 1;
    end
  end
endmodule // irq_pin_source

// ==== verification/ext_irq4_5_edge_filter_tb_top.sv ====
`timescale 1ns/1ns
`include "ext_irq_params.svh"
`define CHK(nm, e, g) begin samplesChecked++; if ((g) !== (e)) begin nErrors++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end

module ext_irq4_5_edge_filter_tb_top
  import ext_irq_pkg::*;
;
  logic        clock;
  logic        rst_b;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        lvl4;
  logic        lvl5;
  logic        outMode;
  logic        pin4;
  logic        pin5;
  logic        lfClock;
  opmode_type  opMode;
  logic        irq4Req;
  logic        irq5Req;
  logic        irqOut;
  int          nErrors;
  int          samplesChecked;
  int          n4;
  int          n5;
  int          cycles;
  opmode_type  halts [3];

  irq_pin_source #(.LF_HALF(4)) src (.clock(clock), .rst_b(rst_b), .lvl4(lvl4),
    .lvl5(lvl5), .outMode(outMode), .pin4(pin4), .pin5(pin5), .lfClock(lfClock));

  ext_irq4_5_edge_filter uut (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .extIrq4Pin(pin4), .extIrq5Pin(pin5), .lowFreqClock(lfClock), .opMode(opMode),
    .irq4Req(irq4Req), .irq5Req(irq5Req), .irqOut(irqOut));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge clock) begin
    if (irq4Req === 1'b1) n4 = n4 + 1;
    if (irq5Req === 1'b1) n5 = n5 + 1;
    cycles = cycles + 1;
    if (cycles == 20000) begin
      nErrors++;
      tally_and_finish();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clock);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, ofs};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [31:0] v);
    logic [31:0] d;
    ahb(1'b1, ofs, v, d);
  endtask

  task automatic rdc(input logic [7:0] ofs, input logic [31:0] e, input string nm);
    logic [31:0] d;
    ahb(1'b0, ofs, 32'h00000000, d);
    `CHK(nm, e, d)
    `CHK("hresp", `HRESP_OKAY, hresp)
  endtask

  // pulses are widths in gear cycles; pin 5 pulses go low from its idle high
  task automatic pulse(input logic which5, input int w);
    if (which5) lvl5 <= 1'b0;
    else lvl4 <= 1'b1;
    cyc(w);
    if (which5) lvl5 <= 1'b1;
    else lvl4 <= 1'b0;
  endtask

  task automatic tally_and_finish();
    if (nErrors == 0 && samplesChecked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    halts = '{MODE_DEEP_IDLE, MODE_DEEP_SLEEP, MODE_STOP};
    {nErrors, samplesChecked, n4, n5, cycles} = '0;
    {hsel, haddr, htrans, hwrite, hwdata} = '0;
    hsize   = 3'h2;
    lvl4    = 1'b0;
    lvl5    = 1'b1;
    outMode = 1'b0;
    opMode  = MODE_FAST_RUN;
    rst_b   = 1'b0;
    cyc(4);
    rst_b <= 1'b1;
    rdc(`OFS_CONTROL, 32'h0, "control");
    rdc(`OFS_CLK_ENABLE, 32'h0, "clk_enable");
    rdc(`OFS_MASK, 32'h0, "mask");
    rdc(8'h10, 32'h0, "unmapped");
    pulse(1'b0, 40);
    pulse(1'b1, 40);
    cyc(40);
    rdc(`OFS_STATUS, 32'h0, "status_gated");
    wr(`OFS_CLK_ENABLE, 32'h3);
    wr(`OFS_MASK, 32'h3);
    cyc(20);
    wr(`OFS_STATUS, 32'h3);
    // each trigger code against a rise then a fall
    for (int t = 0; t < 4; t++) begin
      wr(`OFS_CONTROL, t);
      n4 = 0;
      lvl4 <= 1'b1;
      cyc(24);
      `CHK("rise_reqs", (t == 1) ? 0 : 1, (t == 3) ? int'(n4 > 10) : n4)
      if (t == 2) rdc(`OFS_CONTROL, 32'h12, "snap_rise");
      n4 = 0;
      lvl4 <= 1'b0;
      cyc(24);
      `CHK("fall_reqs", (t == 0) ? 0 : 1, (t == 3) ? int'(n4 < 8) : n4)
      if (t == 2) rdc(`OFS_CONTROL, 32'h02, "snap_fall");
      wr(`OFS_STATUS, 32'h3);
    end
    wr(`OFS_CONTROL, 32'h0);
    pulse(1'b0, 24);
    cyc(12);
    rdc(`OFS_STATUS, 32'h1, "status_set");
    `CHK("irq_on", 1'b1, irqOut)
    wr(`OFS_MASK, 32'h2);
    cyc(3);
    `CHK("irq_masked", 1'b0, irqOut)
    wr(`OFS_MASK, 32'h3);
    wr(`OFS_STATUS, 32'h1);
    cyc(3);
    `CHK("irq_cleared", 1'b0, irqOut)
    // short pulse below two intervals dies, a long one passes
    for (int k = 0; k < 4; k++) begin
      wr(`OFS_CONTROL, k << 2);
      n4 = 0;
      pulse(1'b0, (k == 0) ? 1 : (4 << k) - 1);
      cyc(4 * (2 << k) + 8);
      pulse(1'b0, 4 * (2 << k) + 4);
      cyc(4 * (2 << k) + 8);
      `CHK("filtered_reqs", 1, n4)
    end
    wr(`OFS_CONTROL, 32'h0);
    n5 = 0;
    pulse(1'b1, 2);
    cyc(12);
    `CHK("pin5_fast_reqs", 1, n5)
    wr(`OFS_STATUS, 32'h3);
    wr(`OFS_MASK, 32'h0);
    outMode <= 1'b1;
    cyc(12);
    rdc(`OFS_STATUS, 32'h2, "status_outmode");
    `CHK("irq_outmode", 1'b0, irqOut)
    outMode <= 1'b0;
    wr(`OFS_MASK, 32'h0);
    opMode <= MODE_SLOW_SLEEP;
    cyc(96);
    wr(`OFS_STATUS, 32'h3);
    wr(`OFS_MASK, 32'h3);
    {n4, n5} = '0;
    pulse(1'b1, 24);
    cyc(80);
    pulse(1'b1, 64);
    cyc(80);
    `CHK("pin5_slow_reqs", 1, n5)
    opMode <= MODE_SLOW_RUN;
    pulse(1'b0, 24);
    cyc(80);
    pulse(1'b0, 64);
    cyc(80);
    `CHK("pin4_slow_reqs", 1, n4)
    wr(`OFS_MASK, 32'h0);
    opMode <= MODE_FAST_RUN;
    cyc(5);
    wr(`OFS_STATUS, 32'h3);
    wr(`OFS_MASK, 32'h3);
    for (int m = 0; m < 3; m++) begin
      opMode <= halts[m];
      {n4, n5} = '0;
      pulse(1'b0, 40);
      pulse(1'b1, 40);
      cyc(40);
      `CHK("halted_reqs", 0, n4 + n5)
      opMode <= MODE_FAST_RUN;
      cyc(20);
    end
    opMode <= MODE_FAST_IDLE;
    n4 = 0;
    pulse(1'b0, 20);
    cyc(24);
    `CHK("resumed_reqs", 1, n4)
    tally_and_finish();
  end
endmodule // ext_irq4_5_edge_filter_tb_top
